//--- hw/ibw_defines.svh
`ifndef IBW_DEFINES_SVH
`define IBW_DEFINES_SVH
// ************************************************************
// register map on the extended register window
// ************************************************************
`define IBW_EXT_STATUS      3'h7    // status and bank selector, every bank
`define IBW_EXT_ROUTE       3'h6    // routing (bank 15) and edge select (bank 14)
`define IBW_EXT_STRETCH     3'h3    // bus stretch control, bank 15
`define IBW_BANK_ROUTE      4'hF
`define IBW_BANK_EDGE       4'hE
`define IBW_BANK_STRETCH    4'hF
// ************************************************************
// field positions
// ************************************************************
`define IBW_BANK_LSB        0       // bank selector, four bits
`define IBW_STAT_LSB        8       // pending bits, one per source
`define IBW_TOP_LSB         0       // top request source index
`define IBW_SEC_LSB         4       // second request source index
`define IBW_EN_LSB          8       // shared request enables
`define IBW_STR_RD_LSB      0       // read wait enables, ext 0..6
`define IBW_STR_WR_LSB      7       // write wait enables, ext 0..6
`define IBW_STR_PIN_BIT     14      // stretch pin takes over from port bit
// ************************************************************
// reset values and timing
// ************************************************************
`define IBW_RST_STATUS      16'h0000
`define IBW_RST_ROUTE       16'h0000
`define IBW_RST_EDGE        16'h0000
`define IBW_RST_STRETCH     16'h0000
`define IBW_WAIT_CYCLES     1       // one system clock per inserted wait
`endif

//--- hw/ibw_pkg.sv
package ibw_pkg;
    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [3:0] {
        IBW_IDLE = 4'h1,    // no external access
        IBW_ACC  = 4'h2,    // base access cycle
        IBW_WAIT = 4'h4,    // fixed wait state
        IBW_STR  = 4'h8     // stretched by the pin
    } ibw_state_e;

    typedef struct packed {
        logic [2:0]  addr;  // extended register index
        logic        rd;    // one-cycle read request
        logic        wr;    // one-cycle write request
        logic [15:0] wdata; // write data
    } ibw_req_s;

    typedef struct packed {
        logic [2:0]  addr;  // external register index
        logic        rd;    // read strobe, held for the access
        logic        wr;    // write strobe, held for the access
        logic        oe;    // data bus output enable
        logic [15:0] wdata; // data driven while oe
    } ibw_ed_s;
endpackage

//--- hw/ibw_ctrl.sv
`timescale 1ns/10ps
`include "ibw_defines.svh"
// ************************************************************
// Contract
// - low four bits pick working bank
// - status bit one means pending
// - writing one clears status, zero keeps
// - read-back write clears pending, keeps bank
// - low field picks top request source
// - second field picks second request source
// - upper byte enables shared sources
// - other enabled sources go to shared
// - unrouted source raises nothing
// - per-pin polarity picks rising or falling
// - enabled wait adds one wait state
// - active-low stretch pin prolongs access
// - wait select per ext 0..6, rd/wr
// - status register access never waits
// - stretch pin works only with bit 14
// ************************************************************
module ibw_ctrl #(
    parameter int NSRC        = 8,                  // interrupt sources
    parameter int NPIN        = 3,                  // external interrupt pins
    parameter int WAIT_CYCLES = `IBW_WAIT_CYCLES    // clocks per fixed wait
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst,
    input  wire logic             i_ce,
    input  wire ibw_pkg::ibw_req_s i_core_req,
    output logic [15:0]           o_core_rdata,
    output logic                  o_core_ready,
    output logic [3:0]            o_bank,
    output ibw_pkg::ibw_ed_s      o_ed,
    input  wire logic [15:0]      i_ed_rdata,
    input  wire logic             i_stretch_n,
    output logic                  o_port_bit,
    input  wire logic [NPIN-1:0]  i_irq_pin,
    input  wire logic [NSRC-1:0]  i_irq_evt,
    output logic                  o_irq_top,
    output logic                  o_irq_sec,
    output logic                  o_irq_shared
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [3:0]      bank_r;        // working bank
    logic [NSRC-1:0] stat_r;        // pending bits
    logic [15:0]     route_r;       // routing
    logic [15:0]     edge_r;        // polarity per pin, one = falling
    logic [15:0]     str_r;         // wait-state control
    ibw_pkg::ibw_state_e st_r;      // access sequencer
    ibw_pkg::ibw_req_s   req_r;     // latched external request
    logic [7:0]      wcnt_r;        // fixed wait counter
    logic            ws_need_r;     // this access takes a fixed wait
    logic [15:0]     rdata_r;
    logic            ready_r;
    ibw_pkg::ibw_ed_s ed_r;
    logic            top_r, sec_r, shr_r, port_r;

    // one-hot mask of the source a four-bit field names; codes past NSRC name none
    function automatic logic [NSRC-1:0] src_mask(input logic [3:0] f);
        logic [NSRC-1:0] m;
        m = '0;
        for (int k = 0; k < NSRC; k++) begin
            if (f == k[3:0]) begin
                m[k] = 1'b1;
            end
        end
        return m;
    endfunction

    // ************************************************************
    // pin synchronisers: three stages, a change counts when 2 and 3 agree
    // ************************************************************
    logic [NPIN:0] s1_r, s2_r, s3_r, stab_r, stab_d_r;
    wire  [NPIN:0] pin_in = {i_stretch_n, i_irq_pin};
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_r     <= '1;
            s2_r     <= '1;
            s3_r     <= '1;
            stab_r   <= '1;
            stab_d_r <= '1;
        end else if (i_ce) begin
            s1_r     <= pin_in;
            s2_r     <= s1_r;
            s3_r     <= s2_r;
            stab_r   <= (s2_r == s3_r) ? s3_r : stab_r;   // filters a single glitch
            stab_d_r <= stab_r;
        end
    end

    // ************************************************************
    // trigger detection and routing
    // ************************************************************
    logic [NSRC-1:0] trig;          // raw trigger per source
    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : g_trig
            if (g < NPIN) begin : g_pin
                // polarity picks which edge of the pin counts
                assign trig[g] = edge_r[g] ? (stab_d_r[g] & ~stab_r[g])
                                           : (~stab_d_r[g] & stab_r[g]);
            end else begin : g_evt
                assign trig[g] = i_irq_evt[g];
            end
        end
    endgenerate

    wire [NSRC-1:0] top_m = src_mask(route_r[`IBW_TOP_LSB+:4]);
    wire [NSRC-1:0] sec_m = src_mask(route_r[`IBW_SEC_LSB+:4]) & ~top_m;
    wire [NSRC-1:0] shr_m = route_r[`IBW_EN_LSB+:NSRC] & ~top_m & ~sec_m;
    wire [NSRC-1:0] routed = top_m | sec_m | shr_m;
    wire [NSRC-1:0] trig_routed = trig & routed;

    // ************************************************************
    // register access decode
    // ************************************************************
    wire acc_go   = i_ce && (st_r == ibw_pkg::IBW_IDLE) && (i_core_req.rd || i_core_req.wr);
    wire hit_stat = (i_core_req.addr == `IBW_EXT_STATUS);
    wire hit_rte  = (i_core_req.addr == `IBW_EXT_ROUTE) && (bank_r == `IBW_BANK_ROUTE);
    wire hit_edg  = (i_core_req.addr == `IBW_EXT_ROUTE) && (bank_r == `IBW_BANK_EDGE);
    wire hit_str  = (i_core_req.addr == `IBW_EXT_STRETCH) && (bank_r == `IBW_BANK_STRETCH);
    wire int_hit  = hit_stat | hit_rte | hit_edg | hit_str;
    wire wr_int   = acc_go && i_core_req.wr;
    wire stat_wr  = wr_int && hit_stat;
    // per register and direction wait select; the status register has no bit
    wire ws_sel   = i_core_req.wr ? str_r[`IBW_STR_WR_LSB + i_core_req.addr]
                                  : str_r[`IBW_STR_RD_LSB + i_core_req.addr];
    // stretch pin counts only in wait mode; otherwise it is a port bit
    wire stretch_act = str_r[`IBW_STR_PIN_BIT] && !stab_r[NPIN];

    // status and bank: set beats clear so an event in the clear cycle survives
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            bank_r <= 4'(`IBW_RST_STATUS);
            stat_r <= '0;
        end else if (i_ce) begin
            if (stat_wr) begin
                bank_r <= i_core_req.wdata[`IBW_BANK_LSB+:4];
            end
            stat_r <= (stat_r & ~(stat_wr ? i_core_req.wdata[`IBW_STAT_LSB+:NSRC] : '0))
                      | trig_routed;
        end
    end

    // configuration registers, reachable only in their bank
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            route_r <= `IBW_RST_ROUTE;
            edge_r  <= `IBW_RST_EDGE;
            str_r   <= `IBW_RST_STRETCH;
        end else if (wr_int) begin
            if (hit_rte) begin
                route_r <= i_core_req.wdata;
            end
            if (hit_edg) begin
                edge_r <= i_core_req.wdata;
            end
            if (hit_str) begin
                str_r <= i_core_req.wdata;
            end
        end
    end

    // request outputs are levels while any routed bit is pending
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            top_r  <= 1'b0;
            sec_r  <= 1'b0;
            shr_r  <= 1'b0;
            port_r <= 1'b1;
        end else if (i_ce) begin
            top_r  <= |(stat_r & top_m);
            sec_r  <= |(stat_r & sec_m);
            shr_r  <= |(stat_r & shr_m);
            port_r <= str_r[`IBW_STR_PIN_BIT] ? 1'b1 : stab_r[NPIN];
        end
    end

    // ************************************************************
    // access sequencer; the pin is seen 4 clocks late, so a slow part
    // must pull it low before the access starts
    // ************************************************************
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r      <= ibw_pkg::IBW_IDLE;
            req_r     <= '0;
            wcnt_r    <= '0;
            ws_need_r <= 1'b0;
            ed_r      <= '0;
            rdata_r   <= '0;
            ready_r   <= 1'b0;
        end else if (i_ce) begin
            ready_r <= 1'b0;
            case (st_r)
                ibw_pkg::IBW_IDLE: begin
                    if (acc_go && int_hit) begin
                        // internal: answered next clock, no wait at all
                        ready_r <= 1'b1;
                        rdata_r <= hit_stat ? {stat_r, 4'h0, bank_r}
                                 : hit_rte ? route_r : hit_edg ? edge_r : str_r;
                    end else if (acc_go) begin
                        req_r     <= i_core_req;
                        ws_need_r <= ws_sel;
                        ed_r      <= '{addr: i_core_req.addr, rd: i_core_req.rd,
                                       wr: i_core_req.wr, oe: i_core_req.wr,
                                       wdata: i_core_req.wdata};
                        st_r      <= ibw_pkg::IBW_ACC;
                    end
                end
                ibw_pkg::IBW_ACC: begin
                    if (ws_need_r) begin
                        wcnt_r <= 8'(WAIT_CYCLES - 1);
                        st_r   <= ibw_pkg::IBW_WAIT;
                    end else if (stretch_act) begin
                        st_r <= ibw_pkg::IBW_STR;
                    end else begin
                        st_r    <= ibw_pkg::IBW_IDLE;
                        ready_r <= 1'b1;
                        rdata_r <= i_ed_rdata;
                        ed_r    <= '0;
                    end
                end
                ibw_pkg::IBW_WAIT: begin
                    if (wcnt_r != 8'h00) begin
                        wcnt_r <= wcnt_r - 8'h01;
                    end else if (stretch_act) begin
                        st_r <= ibw_pkg::IBW_STR;
                    end else begin
                        st_r    <= ibw_pkg::IBW_IDLE;
                        ready_r <= 1'b1;
                        rdata_r <= i_ed_rdata;
                        ed_r    <= '0;
                    end
                end
                ibw_pkg::IBW_STR: begin
                    if (!stretch_act) begin
                        st_r    <= ibw_pkg::IBW_IDLE;
                        ready_r <= 1'b1;
                        rdata_r <= i_ed_rdata;
                        ed_r    <= '0;
                    end
                end
                default: begin
                    st_r <= ibw_pkg::IBW_IDLE;
                    ed_r <= '0;
                end
            endcase
        end
    end

    assign o_core_rdata = rdata_r;
    assign o_core_ready = ready_r;
    assign o_bank       = bank_r;
    assign o_ed         = ed_r;
    assign o_port_bit   = port_r;
    assign o_irq_top    = top_r;
    assign o_irq_sec    = sec_r;
    assign o_irq_shared = shr_r;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    a_bank_write: assert property (stat_wr |=> bank_r == $past(i_core_req.wdata[3:0]))
        else $error("bank selector not taken from write");
    a_clear_one: assert property ((stat_wr && !(|trig_routed))
        |=> (stat_r & $past(i_core_req.wdata[`IBW_STAT_LSB+:NSRC])) == '0)
        else $error("status bit survived a write of one");
    a_sticky: assert property ((i_ce && !stat_wr) |=> (stat_r & $past(stat_r)) == $past(stat_r))
        else $error("pending bit lost without a clear");
    a_set_trig: assert property (i_ce |=> (stat_r & $past(trig_routed)) == $past(trig_routed))
        else $error("routed trigger did not set its bit");
    a_unrouted: assert property (i_ce |=> (stat_r & ~$past(stat_r) & ~$past(routed)) == '0)
        else $error("unrouted source set a bit");
    a_top_req: assert property ((i_ce && |(stat_r & top_m)) |=> o_irq_top)
        else $error("top request missing");
    a_int_nowait: assert property ((acc_go && int_hit) |=> o_core_ready)
        else $error("internal access waited");
    a_fixed_wait: assert property ((i_ce && st_r == ibw_pkg::IBW_ACC && ws_need_r)
        |=> st_r == ibw_pkg::IBW_WAIT && !o_core_ready)
        else $error("fixed wait state not inserted");
    a_stretch_hold: assert property ((i_ce && st_r == ibw_pkg::IBW_STR && stretch_act)
        |=> st_r == ibw_pkg::IBW_STR && o_ed == $past(o_ed))
        else $error("access ended while stretched");
    a_pin_mode: assert property (stretch_act |-> str_r[`IBW_STR_PIN_BIT])
        else $error("stretch without pin mode");

    c_ext_plain: cover property (st_r == ibw_pkg::IBW_ACC ##1 o_core_ready);
    c_ext_wait:  cover property (st_r == ibw_pkg::IBW_WAIT ##1 o_core_ready);
    c_stretch:   cover property (st_r == ibw_pkg::IBW_STR ##1 st_r == ibw_pkg::IBW_STR);
    c_shared:    cover property (o_irq_shared && o_irq_top);
endmodule

//--- verification/ibw_periph.sv
`timescale 1ns/10ps
// ************************************************************
// slow peripheral on the external data bus
// ************************************************************
module ibw_periph #(
    parameter int HOLD = 5                  // access cycles the pin stays low
) (
    input  wire logic             i_core_clk,
    input  wire ibw_pkg::ibw_ed_s i_ed,
    input  wire logic             i_slow,
    output logic [15:0]           o_rdata,
    output logic                  o_stretch_n,
    output logic [15:0]           o_wdata
);
    logic [7:0] cnt_r;                      // cycles into the current access
    logic [7:0] run_r = 8'h00;              // free counter for idle noise
    // count access cycles and capture what is written
    always_ff @(posedge i_core_clk) begin
        run_r <= run_r + 8'h01;
        cnt_r <= (i_ed.rd | i_ed.wr) ? cnt_r + 8'h01 : 8'h00;
        if (i_ed.wr) begin
            o_wdata <= i_ed.wdata;
        end
    end
    // data only while read; otherwise a pattern that moves every cycle
    assign o_rdata = i_ed.rd ? {i_ed.addr, 13'h0A5C} : {8'hE1, run_r};
    // held low ahead of the access, since the pin is seen late through the sync
    assign o_stretch_n = !(i_slow && (cnt_r < HOLD));
endmodule

//--- verification/interrupt_bank_waitstate_ctrl_tb_top.sv
`timescale 1ns/10ps
module interrupt_bank_waitstate_ctrl_tb_top;
    // ************************************************************
    // signals
    // ************************************************************
    localparam int HOLD = 5;                // peripheral stretch length
    logic              clk = 1'b0;          // 250 MHz core clock
    logic              rst = 1'b1;          // async reset
    logic              ce = 1'b1;           // kept running
    ibw_pkg::ibw_req_s req = '0;            // register request
    ibw_pkg::ibw_ed_s  ed;                  // external bus
    logic [15:0]       rdata, ed_rdata, wseen, rd_v, route, wmask, r16;
    logic [7:0]        evt = 8'h00, ev, exp_p;
    logic [2:0]        pin = 3'h7, pol, a;
    logic              ready, stretch_n, port_bit, i_top, i_sec, i_shr, w;
    logic [3:0]        bank;
    logic              slow = 1'b0;
    logic [31:0]       seed = 32'h79446B63;
    int                error_cnt = 0, total_checks = 0, lat, cyc = 0;
    always #2 clk = ~clk;
    ibw_ctrl dut_u (.i_core_clk(clk), .i_rst(rst), .i_ce(ce), .i_core_req(req),
        .o_core_rdata(rdata), .o_core_ready(ready), .o_bank(bank), .o_ed(ed),
        .i_ed_rdata(ed_rdata), .i_stretch_n(stretch_n), .o_port_bit(port_bit),
        .i_irq_pin(pin), .i_irq_evt(evt), .o_irq_top(i_top), .o_irq_sec(i_sec),
        .o_irq_shared(i_shr));
    ibw_periph #(.HOLD(HOLD)) periph_u (.i_core_clk(clk), .i_ed(ed), .i_slow(slow),
        .o_rdata(ed_rdata), .o_stretch_n(stretch_n), .o_wdata(wseen));
    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    // sources that may set a pending bit; index 8 and up picks none
    function automatic logic [7:0] routed(input logic [15:0] r);
        logic [7:0] m;
        m = r[15:8];
        if (!r[3]) m[r[2:0]] = 1'b1;
        if (!r[7]) m[r[6:4]] = 1'b1;
        return m;
    endfunction
    // {top, second, shared}; top wins when both fields name one source
    function automatic logic [2:0] irqs(input logic [15:0] r, input logic [7:0] p);
        logic [7:0] sh;
        logic       t, s;
        sh = r[15:8] & p;
        t = !r[3] && p[r[2:0]];
        s = !r[7] && (r[7:4] != r[3:0]) && p[r[6:4]];
        if (!r[3]) sh[r[2:0]] = 1'b0;
        if (!r[7]) sh[r[6:4]] = 1'b0;
        return {t, s, |sh};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one request pulse, then count cycles until ready
    task automatic acc(input logic [2:0] ad, input logic wr, input logic [15:0] d);
        @(posedge clk);
        #1;
        req = '{addr: ad, rd: !wr, wr: wr, wdata: d};
        @(posedge clk);
        #1;
        req.rd = 1'b0;
        req.wr = 1'b0;
        lat = 1;
        while (ready !== 1'b1 && lat < 40) begin
            @(posedge clk);
            #1;
            lat++;
        end
        rd_v = rdata;
    endtask
    // bank change leaves pending bits alone since bits 15:8 are zero
    task automatic sb(input logic [3:0] b);
        acc(3'h7, 1'b1, {12'h000, b});
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            stop_test();
        end
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        chk({bank, port_bit, i_top, i_sec, i_shr}, 16'h0008);
        acc(3'h7, 1'b0, 16'h0000);
        chk(rd_v, 16'h0000);
        sb(4'hF);
        chk({12'h000, bank}, 16'h000F);
        // random routing, events, masked clears and read-back clears
        for (int i = 0; i < 24; i++) begin
            r16 = rnd();
            route = (i == 0) ? 16'h0033 : (i == 1) ? 16'h00F8 : r16;
            acc(3'h6, 1'b1, route);
            acc(3'h6, 1'b0, 16'h0000);
            chk(rd_v, route);
            r16 = rnd();
            ev = (i == 2) ? 8'hF8 : (r16[7:0] & 8'hF8);
            @(posedge clk);
            #1;
            evt = ev;
            @(posedge clk);
            #1;
            evt = 8'h00;
            @(posedge clk);
            #1;
            exp_p = ev & routed(route);
            chk({13'h0000, i_top, i_sec, i_shr}, {13'h0000, irqs(route, exp_p)});
            acc(3'h7, 1'b0, 16'h0000);
            chk(rd_v, {exp_p, 8'h0F});
            acc(3'h7, 1'b1, {r16[15:8], 8'h0F});
            acc(3'h7, 1'b0, 16'h0000);
            chk(rd_v, {exp_p & ~r16[15:8], 8'h0F});
            acc(3'h7, 1'b1, rd_v);
            acc(3'h7, 1'b0, 16'h0000);
            chk(rd_v, 16'h000F);
        end
        // pin polarity: a falling then a rising edge on all pins
        acc(3'h6, 1'b1, 16'hFF88);
        for (int p = 0; p < 3; p++) begin
            r16 = rnd();
            pol = r16[2:0];
            sb(4'hE);
            acc(3'h6, 1'b1, {13'h0000, pol});
            sb(4'hF);
            pin = 3'h0;
            repeat (8) @(posedge clk);
            #1;
            acc(3'h7, 1'b0, 16'h0000);
            chk(rd_v, {5'h00, pol, 8'h0F});
            acc(3'h7, 1'b1, 16'hFF0F);
            pin = 3'h7;
            repeat (8) @(posedge clk);
            #1;
            acc(3'h7, 1'b0, 16'h0000);
            chk(rd_v, {5'h00, ~pol, 8'h0F});
            acc(3'h7, 1'b1, 16'hFF0F);
        end
        // external accesses with random wait enables per register and direction
        for (int i = 0; i < 28; i++) begin
            r16 = rnd();
            wmask = {2'b00, r16[13:0]};
            a = 3'(i % 7);
            w = r16[14];
            sb(4'hF);
            acc(3'h3, 1'b1, wmask);
            sb(4'h0);
            acc(a, w, r16 ^ 16'h5A5A);
            chk(16'(lat), 16'(2 + int'(w ? wmask[7 + a] : wmask[a])));
            chk(w ? wseen : rd_v, w ? (r16 ^ 16'h5A5A) : {a, 13'h0A5C});
        end
        // stretch pin ignored without bit 14, then prolonging with it
        sb(4'hF);
        acc(3'h3, 1'b1, 16'h0000);
        slow = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        chk({15'h0000, port_bit}, 16'h0000);
        sb(4'h0);
        acc(3'h1, 1'b0, 16'h0000);
        chk(16'(lat), 16'h0002);
        sb(4'hF);
        acc(3'h3, 1'b1, 16'h7FFF);
        @(posedge clk);
        #1;
        chk({15'h0000, port_bit}, 16'h0001);
        sb(4'h0);
        acc(3'h2, 1'b0, 16'h0000);
        chk({15'h0000, lat >= HOLD + 3 && lat <= HOLD + 10}, 16'h0001);
        acc(3'h7, 1'b0, 16'h0000);
        chk(16'(lat), 16'h0001);
        slow = 1'b0;
        stop_test();
    end
endmodule
